// *** shared/adcr_pkg.sv ***
// adcr_pkg: register map, field layout, reset values and types of the adc register bank
package adcr_pkg;

	// ------------------------------------------------------------
	// register addresses (5-bit register select field)
	// ------------------------------------------------------------
	localparam logic [4:0] ADDR_STATUS = 5'h00;
	localparam logic [4:0] ADDR_CALIB_POWER_FORMAT_CONTROL = 5'h01;
	localparam logic [4:0] ADDR_CLOCK_LDO_GAIN_CONTROL = 5'h02;
	localparam logic [4:0] ADDR_SYNC_CALREG_CONTROL = 5'h03;
	localparam logic [4:0] ADDR_GPIO = 5'h04;
	localparam logic [4:0] ADDR_DELAY = 5'h05;
	localparam logic [4:0] ADDR_CHMAP_HI = 5'h06;
	localparam logic [4:0] ADDR_CHMAP_LO = 5'h07;
	localparam logic [4:0] ADDR_SEQ = 5'h08;
	localparam logic [4:0] ADDR_GPO = 5'h09;
	localparam logic [4:0] ADDR_SOC = 5'h0a;
	localparam logic [4:0] ADDR_SGC = 5'h0b;
	localparam logic [4:0] ADDR_SYSTEM_OFFSET_CALIB = 5'h0c;
	localparam logic [4:0] ADDR_SYSTEM_GAIN_CALIB = 5'h0d;
	localparam logic [4:0] ADDR_RESULT_CHANNEL_0 = 5'h0e;
	localparam logic [4:0] ADDR_RESULT_CHANNEL_5 = 5'h13;

	// ------------------------------------------------------------
	// conversion-time write classes, one bit per address 0..19
	// ------------------------------------------------------------
	localparam logic [19:0] CLASS_ABORT = 20'h0000e;
	localparam logic [19:0] CLASS_IGNORE = 20'h03ce0;

	// ------------------------------------------------------------
	// field positions and masks
	// ------------------------------------------------------------
	localparam int CLOCK_LDO_GAIN_CONTROL_LDO_BIT = 5;
	localparam int SYNC_CALREG_CONTROL_CSS_BIT = 7;
	localparam int STAT_SRDY_LSB = 16;
	localparam int STAT_PD_LSB = 2;
	localparam int STAT_MSTAT_BIT = 1;
	localparam int STAT_RSVD_BIT = 23;
	localparam logic [23:0] STAT_RETAIN_MASK = 24'h3f000d;
	localparam logic [23:0] STAT_FLAGS_MASK = 24'h40fff1;
	localparam logic [7:0] GPO_MASK = 8'h07;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [23:0] STAT_RST = 24'h004000;
	localparam logic [7:0] CALIB_POWER_FORMAT_CONTROL_RST = 8'h00;
	localparam logic [7:0] CLOCK_LDO_GAIN_CONTROL_RST = 8'h20;
	localparam logic [7:0] SYNC_CALREG_CONTROL_RST = 8'h00;

	// power state codes shown in status
	localparam logic [1:0] PD_CONV = 2'h0;
	localparam logic [1:0] PD_SLEEP = 2'h1;
	localparam logic [1:0] PD_STANDBY = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PS_STANDBY = 3'b001,
		PS_CONV = 3'b010,
		PS_SLEEP = 3'b100
	} adcr_pwr_t;

	typedef struct packed {
		logic [7:0] calib_power_format_control;
		logic [7:0] clock_ldo_gain_control;
		logic [7:0] sync_calreg_control;
		logic [7:0] gpio;
		logic [15:0] delay;
		logic [23:0] chmap_hi;
		logic [23:0] chmap_lo;
		logic [7:0] seq;
		logic [7:0] gpo;
		logic [3:0][23:0] cal;
	} adcr_cfg_t;

	typedef struct packed {
		adcr_pwr_t pwr;
		adcr_cfg_t cfg;
		logic [23:0] rdata;
		logic rvalid;
		logic abort;
		logic sleep_ent;
	} adcr_bank_t;

	typedef struct packed {
		logic [23:0] word;
	} adcr_stat_t;

	typedef struct packed {
		logic [5:0][23:0] data;
	} adcr_res_t;

endpackage : adcr_pkg

// *** logic/adcr_status.sv ***
// adcr_status: status word with sticky ready flags and sleep retention
`timescale 1ns/1ns
module adcr_status (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic load_i,
	input wire logic [23:0] flags_i,
	input wire logic [5:0] srdy_set_i,
	input wire logic [5:0] srdy_clr_i,
	input wire logic scan_start_i,
	input wire logic sleep_ent_i,
	input wire logic [1:0] pdstat_i,
	input wire logic mstat_i,
	output logic [23:0] word_o
);

	adcr_pkg::adcr_stat_t r;
	adcr_pkg::adcr_stat_t n;
	logic [5:0] srdy;

	// ------------------------------------------------------------
	// next status word
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		srdy = r.word[adcr_pkg::STAT_SRDY_LSB +: 6];
		if (scan_start_i) begin
			srdy = 6'h00;
		end
		srdy = (srdy & ~srdy_clr_i) | srdy_set_i; // set beats clear
		if (load_i) begin
			n.word = (r.word & ~adcr_pkg::STAT_FLAGS_MASK) | (flags_i & adcr_pkg::STAT_FLAGS_MASK);
		end
		n.word[adcr_pkg::STAT_SRDY_LSB +: 6] = srdy;
		n.word[adcr_pkg::STAT_PD_LSB +: 2] = pdstat_i;
		n.word[adcr_pkg::STAT_MSTAT_BIT] = mstat_i;
		n.word[adcr_pkg::STAT_RSVD_BIT] = 1'b0;
		if (sleep_ent_i) begin
			n.word = n.word & adcr_pkg::STAT_RETAIN_MASK;
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r.word <= adcr_pkg::STAT_RST;
		end else begin
			r <= n;
		end
	end

	assign word_o = r.word;

endmodule : adcr_status

// *** logic/adcr_result.sv ***
// adcr_result: six conversion result registers, written by the core, read by the host
`timescale 1ns/1ns
module adcr_result (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic we_i,
	input wire logic [2:0] wch_i,
	input wire logic [23:0] wdata_i,
	input wire logic [2:0] rch_i,
	output logic [23:0] rdata_o
);

	adcr_pkg::adcr_res_t r;
	adcr_pkg::adcr_res_t n;

	// ------------------------------------------------------------
	// result load, contents kept through sleep
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		if (we_i && (wch_i < 3'h6)) begin
			n.data[wch_i] = wdata_i;
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// read port, out-of-range channel reads zero
	assign rdata_o = (rch_i < 3'h6) ? r.data[rch_i] : 24'h000000;

endmodule : adcr_result

// *** logic/adcr_regbank.sv ***
// adcr_regbank: register bank of a six-channel delta-sigma adc
//
// Behaviour
// - write to any control register during conversion aborts it, enters standby.
// - write to delay, channel maps or calibration during conversion is dropped.
// - gpio, sequencer and output-port registers behave the same during conversion.
// - registers with full retention keep their whole value through sleep.
// - sleep clears status except ready flags, power-state field and ready bit.
// - 5-bit register select decodes addresses 0 to 19 onto the register map.
// - core regulator enable at 0 switches off the internal core regulator.
// - sensor current enable turns on both test source and test sink.
`timescale 1ns/1ns
module adcr_regbank (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [4:0] REG_ADDR_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [23:0] REG_WDATA_I,
	output logic [23:0] REG_RDATA_O,
	output logic REG_RVALID_O,
	input wire logic CONV_START_I,
	input wire logic CONV_DONE_I,
	input wire logic SLEEP_I,
	input wire logic STAT_LOAD_I,
	input wire logic [23:0] STAT_FLAGS_I,
	input wire logic [5:0] SRDY_SET_I,
	input wire logic RES_WE_I,
	input wire logic [2:0] RES_CH_I,
	input wire logic [23:0] RES_DATA_I,
	output logic CONV_ACTIVE_O,
	output logic SLEEP_ACTIVE_O,
	output logic CONV_ABORT_O,
	output logic CORE_REGULATOR_ENABLE_O,
	output logic SENSOR_CURRENT_ENABLE_O,
	output adcr_pkg::adcr_cfg_t CFG_O
);

	// ------------------------------------------------------------
	// state and local signals
	// ------------------------------------------------------------
	adcr_pkg::adcr_bank_t r;
	adcr_pkg::adcr_bank_t n;

	logic addr_ok;
	logic busy;
	logic cls_abort;
	logic cls_ignore;
	logic wr_take;
	logic wr_abort;
	logic [1:0] cal_idx;
	logic [2:0] data_idx;
	logic [23:0] stat_word;
	logic [23:0] res_word;
	logic [5:0] srdy_clr;
	logic scan_start;
	logic [1:0] pdstat;
	logic [31:0] abort_map;
	logic [31:0] ignore_map;

	// ------------------------------------------------------------
	// address decode and write classes
	// ------------------------------------------------------------
	assign addr_ok = (REG_ADDR_I <= adcr_pkg::ADDR_RESULT_CHANNEL_5);
	assign busy = (r.pwr == adcr_pkg::PS_CONV);
	// class tables widened so every 5-bit select indexes inside them
	assign abort_map = 32'(adcr_pkg::CLASS_ABORT);
	assign ignore_map = 32'(adcr_pkg::CLASS_IGNORE);
	assign cls_abort = addr_ok && abort_map[REG_ADDR_I];
	assign cls_ignore = addr_ok && ignore_map[REG_ADDR_I];

	// ignore class is locked while converting, normal class never is
	assign wr_take = REG_WR_I && addr_ok && !(busy && cls_ignore);
	assign wr_abort = REG_WR_I && busy && cls_abort;

	// index helpers, only meaningful inside their address ranges
	assign cal_idx = 2'(REG_ADDR_I - adcr_pkg::ADDR_SOC);
	assign data_idx = 3'(REG_ADDR_I - adcr_pkg::ADDR_RESULT_CHANNEL_0);

	// a read of a result register clears its ready flag
	assign srdy_clr = (REG_RD_I && (REG_ADDR_I >= adcr_pkg::ADDR_RESULT_CHANNEL_0) && addr_ok)
		? 6'(6'h01 << data_idx) : 6'h00;

	// a conversion start restarts the scan flags
	assign scan_start = CONV_START_I && (r.pwr == adcr_pkg::PS_STANDBY) && !SLEEP_I;

	// ------------------------------------------------------------
	// power-state code for status
	// ------------------------------------------------------------
	always_comb begin
		pdstat = adcr_pkg::PD_STANDBY;
		unique case (r.pwr)
			adcr_pkg::PS_STANDBY: begin
				pdstat = adcr_pkg::PD_STANDBY;
			end
			adcr_pkg::PS_CONV: begin
				pdstat = adcr_pkg::PD_CONV;
			end
			adcr_pkg::PS_SLEEP: begin
				pdstat = adcr_pkg::PD_SLEEP;
			end
			default: begin
				pdstat = adcr_pkg::PD_STANDBY; // illegal one-hot code
			end
		endcase
	end

	// ------------------------------------------------------------
	// status word
	// ------------------------------------------------------------
	adcr_status u_status (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.load_i(STAT_LOAD_I),
		.flags_i(STAT_FLAGS_I),
		.srdy_set_i(SRDY_SET_I),
		.srdy_clr_i(srdy_clr),
		.scan_start_i(scan_start),
		.sleep_ent_i(r.sleep_ent),
		.pdstat_i(pdstat),
		.mstat_i(busy),
		.word_o(stat_word)
	);

	// ------------------------------------------------------------
	// conversion results
	// ------------------------------------------------------------
	adcr_result u_result (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.we_i(RES_WE_I),
		.wch_i(RES_CH_I),
		.wdata_i(RES_DATA_I),
		.rch_i(data_idx),
		.rdata_o(res_word)
	);

	// ------------------------------------------------------------
	// next state: register writes, power states, read data
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		n.abort = 1'b0;
		n.rvalid = 1'b0;
		n.sleep_ent = 1'b0;

		// host writes; status and results have no write path
		// an abort-class write still stores its value while it stops the conversion
		if (wr_take) begin
			unique case (REG_ADDR_I)
				adcr_pkg::ADDR_CALIB_POWER_FORMAT_CONTROL: begin
					n.cfg.calib_power_format_control = REG_WDATA_I[7:0];
				end
				adcr_pkg::ADDR_CLOCK_LDO_GAIN_CONTROL: begin
					n.cfg.clock_ldo_gain_control = REG_WDATA_I[7:0];
				end
				adcr_pkg::ADDR_SYNC_CALREG_CONTROL: begin
					n.cfg.sync_calreg_control = REG_WDATA_I[7:0];
				end
				adcr_pkg::ADDR_GPIO: begin
					n.cfg.gpio = REG_WDATA_I[7:0];
				end
				adcr_pkg::ADDR_DELAY: begin
					n.cfg.delay = REG_WDATA_I[15:0];
				end
				adcr_pkg::ADDR_CHMAP_HI: begin
					n.cfg.chmap_hi = REG_WDATA_I;
				end
				adcr_pkg::ADDR_CHMAP_LO: begin
					n.cfg.chmap_lo = REG_WDATA_I;
				end
				adcr_pkg::ADDR_SEQ: begin
					n.cfg.seq = REG_WDATA_I[7:0];
				end
				adcr_pkg::ADDR_GPO: begin
					n.cfg.gpo = REG_WDATA_I[7:0] & adcr_pkg::GPO_MASK;
				end
				adcr_pkg::ADDR_SOC,
				adcr_pkg::ADDR_SGC,
				adcr_pkg::ADDR_SYSTEM_OFFSET_CALIB,
				adcr_pkg::ADDR_SYSTEM_GAIN_CALIB: begin
					n.cfg.cal[cal_idx] = REG_WDATA_I;
				end
				default: begin
					n.cfg = r.cfg;
				end
			endcase
		end

		// power states; configuration is never cleared on sleep
		// sleep takes priority over an abort and over done
		unique case (r.pwr)
			adcr_pkg::PS_STANDBY: begin
				if (SLEEP_I) begin
					n.pwr = adcr_pkg::PS_SLEEP;
					n.sleep_ent = 1'b1;
				end else if (CONV_START_I) begin
					n.pwr = adcr_pkg::PS_CONV;
				end
			end
			adcr_pkg::PS_CONV: begin
				if (SLEEP_I) begin
					n.pwr = adcr_pkg::PS_SLEEP;
					n.sleep_ent = 1'b1;
				end else if (wr_abort) begin
					n.pwr = adcr_pkg::PS_STANDBY;
					n.abort = 1'b1;
				end else if (CONV_DONE_I) begin
					n.pwr = adcr_pkg::PS_STANDBY;
				end
			end
			adcr_pkg::PS_SLEEP: begin
				if (!SLEEP_I) begin
					n.pwr = adcr_pkg::PS_STANDBY;
				end
			end
			default: begin
				n.pwr = adcr_pkg::PS_STANDBY; // recover from a corrupt state code
			end
		endcase

		// read mux, narrow registers zero-extended
		// a read in the same cycle as a write returns the old value
		if (REG_RD_I) begin
			n.rvalid = 1'b1;
			n.rdata = 24'h000000;
			if (addr_ok) begin
				unique case (REG_ADDR_I)
					adcr_pkg::ADDR_STATUS: begin
						n.rdata = stat_word;
					end
					adcr_pkg::ADDR_CALIB_POWER_FORMAT_CONTROL: begin
						n.rdata = {16'h0000, r.cfg.calib_power_format_control};
					end
					adcr_pkg::ADDR_CLOCK_LDO_GAIN_CONTROL: begin
						n.rdata = {16'h0000, r.cfg.clock_ldo_gain_control};
					end
					adcr_pkg::ADDR_SYNC_CALREG_CONTROL: begin
						n.rdata = {16'h0000, r.cfg.sync_calreg_control};
					end
					adcr_pkg::ADDR_GPIO: begin
						n.rdata = {16'h0000, r.cfg.gpio};
					end
					adcr_pkg::ADDR_DELAY: begin
						n.rdata = {8'h00, r.cfg.delay};
					end
					adcr_pkg::ADDR_CHMAP_HI: begin
						n.rdata = r.cfg.chmap_hi;
					end
					adcr_pkg::ADDR_CHMAP_LO: begin
						n.rdata = r.cfg.chmap_lo;
					end
					adcr_pkg::ADDR_SEQ: begin
						n.rdata = {16'h0000, r.cfg.seq};
					end
					adcr_pkg::ADDR_GPO: begin
						n.rdata = {16'h0000, r.cfg.gpo};
					end
					adcr_pkg::ADDR_SOC,
					adcr_pkg::ADDR_SGC,
					adcr_pkg::ADDR_SYSTEM_OFFSET_CALIB,
					adcr_pkg::ADDR_SYSTEM_GAIN_CALIB: begin
						n.rdata = r.cfg.cal[cal_idx];
					end
					default: begin
						n.rdata = res_word;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// reset gives standby, regulator on, everything else zero
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			r <= '0;
			r.pwr <= adcr_pkg::PS_STANDBY;
			r.cfg.calib_power_format_control <= adcr_pkg::CALIB_POWER_FORMAT_CONTROL_RST;
			r.cfg.clock_ldo_gain_control <= adcr_pkg::CLOCK_LDO_GAIN_CONTROL_RST;
			r.cfg.sync_calreg_control <= adcr_pkg::SYNC_CALREG_CONTROL_RST;
		end else begin
			r <= n;
		end
	end

	// ------------------------------------------------------------
	// outputs, all from flip-flops
	// ------------------------------------------------------------
	assign REG_RDATA_O = r.rdata;
	assign REG_RVALID_O = r.rvalid;
	assign CONV_ACTIVE_O = busy;
	assign SLEEP_ACTIVE_O = (r.pwr == adcr_pkg::PS_SLEEP);
	assign CONV_ABORT_O = r.abort;
	assign CFG_O = r.cfg;

	// regulator off lets the core run from the i/o supply
	assign CORE_REGULATOR_ENABLE_O = r.cfg.clock_ldo_gain_control[adcr_pkg::CLOCK_LDO_GAIN_CONTROL_LDO_BIT];
	// one bit drives both source and sink
	assign SENSOR_CURRENT_ENABLE_O = r.cfg.sync_calreg_control[adcr_pkg::SYNC_CALREG_CONTROL_CSS_BIT];

endmodule : adcr_regbank

// *** tb/adcr_regbank_checker.sv ***
// adcr_regbank_checker: port timing checks for the adc register bank
`timescale 1ns/1ns
module adcr_regbank_checker (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [4:0] REG_ADDR_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [23:0] REG_WDATA_I,
	input wire logic [23:0] REG_RDATA_O,
	input wire logic REG_RVALID_O,
	input wire logic CONV_DONE_I,
	input wire logic SLEEP_I,
	input wire logic STAT_LOAD_I,
	input wire logic CONV_ACTIVE_O,
	input wire logic SLEEP_ACTIVE_O,
	input wire logic CONV_ABORT_O,
	input wire logic CORE_REGULATOR_ENABLE_O,
	input wire logic SENSOR_CURRENT_ENABLE_O,
	input wire adcr_pkg::adcr_cfg_t CFG_O
);
	// ----------------------------------------
	// sequences and properties
	// ----------------------------------------
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	// host write while converting
	sequence s_conv_wr;
		CONV_ACTIVE_O && REG_WR_I && !SLEEP_I && !CONV_DONE_I;
	endsequence
	// settled in sleep, no status load
	sequence s_asleep;
		(SLEEP_ACTIVE_O && !STAT_LOAD_I) [*2];
	endsequence
	property p_abort;
		s_conv_wr ##0 (REG_ADDR_I inside {[1:3]}) |=> CONV_ABORT_O && !CONV_ACTIVE_O;
	endproperty
	a_abort: assert property (p_abort) else $error("control write kept conversion");
	property p_ignore;
		s_conv_wr ##0 (REG_ADDR_I inside {[5:7], [10:13]}) |=> $stable(CFG_O);
	endproperty
	a_ignore: assert property (p_ignore) else $error("ignored write changed config");
	property p_normal;
		s_conv_wr ##0 (REG_ADDR_I == adcr_pkg::ADDR_SEQ) |=> CFG_O.seq == 8'($past(REG_WDATA_I));
	endproperty
	a_normal: assert property (p_normal) else $error("sequencer write lost");
	property p_sleep_cfg;
		!SLEEP_ACTIVE_O && SLEEP_I && !REG_WR_I |=> SLEEP_ACTIVE_O && $stable(CFG_O);
	endproperty
	a_sleep_cfg: assert property (p_sleep_cfg) else $error("sleep entry wrong");
	property p_sleep_stat;
		s_asleep ##0 (REG_RD_I && REG_ADDR_I == adcr_pkg::ADDR_STATUS) |=>
			(REG_RDATA_O & ~adcr_pkg::STAT_RETAIN_MASK) == 24'h000000;
	endproperty
	a_sleep_stat: assert property (p_sleep_stat) else $error("status not masked");
	property p_rvalid;
		REG_RD_I |=> REG_RVALID_O;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_unmapped;
		REG_RD_I && REG_ADDR_I > 5'd19 |=> REG_RDATA_O == 24'h000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_ldo;
		REG_WR_I && REG_ADDR_I == adcr_pkg::ADDR_CLOCK_LDO_GAIN_CONTROL && !REG_WDATA_I[adcr_pkg::CLOCK_LDO_GAIN_CONTROL_LDO_BIT]
			|=> !CORE_REGULATOR_ENABLE_O;
	endproperty
	a_ldo: assert property (p_ldo) else $error("regulator still on");
	property p_css;
		REG_WR_I && REG_ADDR_I == adcr_pkg::ADDR_SYNC_CALREG_CONTROL && REG_WDATA_I[adcr_pkg::SYNC_CALREG_CONTROL_CSS_BIT]
			|=> SENSOR_CURRENT_ENABLE_O;
	endproperty
	a_css: assert property (p_css) else $error("sensor current off");
	property p_ro;
		REG_WR_I && (REG_ADDR_I == 5'd0 || REG_ADDR_I >= 5'd14) |=> $stable(CFG_O);
	endproperty
	a_ro: assert property (p_ro) else $error("read-only write took effect");
endmodule : adcr_regbank_checker

bind adcr_regbank adcr_regbank_checker chk_u (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
	.REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
	.REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
	.CONV_DONE_I(CONV_DONE_I), .SLEEP_I(SLEEP_I), .STAT_LOAD_I(STAT_LOAD_I),
	.CONV_ACTIVE_O(CONV_ACTIVE_O), .SLEEP_ACTIVE_O(SLEEP_ACTIVE_O),
	.CONV_ABORT_O(CONV_ABORT_O), .CORE_REGULATOR_ENABLE_O(CORE_REGULATOR_ENABLE_O),
	.SENSOR_CURRENT_ENABLE_O(SENSOR_CURRENT_ENABLE_O), .CFG_O(CFG_O));

// *** tb/adcr_host_model.sv ***
// adcr_host_model: host stand-in issuing register accesses
`timescale 1ns/1ns
module adcr_host_model (
	input wire logic clk_i,
	input wire logic [23:0] rdata_i,
	input wire logic rvalid_i,
	output logic [4:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [23:0] wdata_o
);
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	// idle bus at time zero
	initial begin
		addr_o = 5'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 24'h000000;
	end
	// one-cycle write, data scrambled once released
	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask : wr
	// one-cycle read, data taken where valid is sampled
	task automatic rd(input logic [4:0] a, output logic [23:0] d, output logic ok);
		ok = 1'b0;
		d = 24'h000000;
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		repeat (4) begin
			@(posedge clk_i);
			if (!ok && rvalid_i === 1'b1) begin
				ok = 1'b1;
				d = rdata_i;
			end
		end
	endtask : rd
endmodule : adcr_host_model

// *** tb/test_adc_config_register_bank.sv ***
// test_adc_config_register_bank: self-checking bench for the adc register bank
`timescale 1ns/1ns
module test_adc_config_register_bank;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] addr;
	logic wr, rd, rvalid, cact, sact, abt, ldo, css;
	logic cst = 1'b0, cdn = 1'b0, slp = 1'b0, sld = 1'b0, rwe = 1'b0;
	logic [23:0] wd, rdata, flg = 24'h000000, rdat = 24'h000000;
	logic [5:0] srdy = 6'h00;
	logic [2:0] rch = 3'h0;
	adcr_pkg::adcr_cfg_t cfg;
	logic [23:0] mdl [20];
	bit conv_m;
	int miscompares, total_checks, seed;
	// ----------------------------------------
	// clock, design, host
	// ----------------------------------------
	always #20 clk = ~clk;
	adcr_regbank dut_u (.CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_WDATA_I(wd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
		.CONV_START_I(cst), .CONV_DONE_I(cdn), .SLEEP_I(slp), .STAT_LOAD_I(sld),
		.STAT_FLAGS_I(flg), .SRDY_SET_I(srdy), .RES_WE_I(rwe), .RES_CH_I(rch),
		.RES_DATA_I(rdat), .CONV_ACTIVE_O(cact), .SLEEP_ACTIVE_O(sact), .CONV_ABORT_O(abt),
		.CORE_REGULATOR_ENABLE_O(ldo), .SENSOR_CURRENT_ENABLE_O(css), .CFG_O(cfg));
	adcr_host_model host_u (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
		.wr_o(wr), .rd_o(rd), .wdata_o(wd));
	// ----------------------------------------
	// checking helpers and model
	// ----------------------------------------
	task automatic give_verdict();
		if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic [23:0] fit(input int a, input logic [23:0] d);
		if (a == 5) return d & 24'h00ffff;
		if (a == 9) return d & 24'h000007;
		if (a inside {6, 7, [10:13]}) return d;
		return d & 24'h0000ff;
	endfunction : fit
	task automatic rd_chk(input int a);
		logic [23:0] d;
		logic ok;
		host_u.rd(a[4:0], d, ok);
		chk("read valid", 24'h000001, {23'h0, ok});
		chk($sformatf("register %0d", a), (a < 20) ? mdl[a] : 24'h000000, d);
	endtask : rd_chk
	task automatic wr_m(input int a, input logic [23:0] d);
		bit ign;
		ign = conv_m && (a inside {[5:7], [10:13]});
		host_u.wr(a[4:0], d);
		if (a inside {[1:13]} && !ign) mdl[a] = fit(a, d);
		if (a inside {[1:3]}) conv_m = 1'b0;
	endtask : wr_m
	task automatic strobe_conv(input bit start);
		@(posedge clk);
		if (start) cst <= 1'b1;
		else cdn <= 1'b1;
		@(posedge clk);
		cst <= 1'b0;
		cdn <= 1'b0;
		conv_m = start;
	endtask : strobe_conv
	// watchdog, some ten thousand cycles
	initial begin
		#400000;
		miscompares++;
		give_verdict();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [23:0] v;
		for (int i = 0; i < 20; i++) mdl[i] = 24'h000000;
		mdl[0] = 24'h004008;
		mdl[2] = 24'h000020;
		seed = $urandom(58);
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// results loaded from the core side
		for (int c = 0; c < 6; c++) begin
			v = 24'($urandom);
			@(posedge clk);
			rwe <= 1'b1;
			rch <= c[2:0];
			rdat <= v;
			mdl[14 + c] = v;
		end
		@(posedge clk);
		rwe <= 1'b0;
		for (int a = 0; a < 21; a++) rd_chk(a);
		rd_chk(25);
		chk("regulator enable", 24'h000001, {23'h0, ldo});
		// random writes everywhere, read-only places untouched
		for (int a = 0; a < 20; a++) wr_m(a, 24'($urandom));
		for (int a = 0; a < 20; a++) rd_chk(a);
		// regulator and sensor current, both levels
		for (int b = 0; b < 2; b++) begin
			wr_m(2, 24'(b << 5));
			wr_m(3, 24'(b << 7));
			#1 chk("regulator enable", 24'(b), {23'h0, ldo});
			chk("sensor current", 24'(b), {23'h0, css});
		end
		// ignored and normal writes while converting
		strobe_conv(1'b1);
		for (int a = 4; a < 14; a++) wr_m(a, 24'($urandom));
		#1 chk("conversion active", 24'h000001, {23'h0, cact});
		strobe_conv(1'b0);
		for (int a = 4; a < 14; a++) rd_chk(a);
		// each control write aborts a conversion
		for (int a = 1; a < 4; a++) begin
			strobe_conv(1'b1);
			wr_m(a, 24'($urandom));
			#1 chk("conversion active", 24'h000000, {23'h0, cact});
			chk("abort pulse", 24'h000001, {23'h0, abt});
			rd_chk(a);
		end
		// status flags, then sleep retention
		@(posedge clk);
		srdy <= 6'h3f;
		sld <= 1'b1;
		flg <= 24'hffffff;
		@(posedge clk);
		srdy <= 6'h00;
		sld <= 1'b0;
		mdl[0] = 24'h7ffff9;
		rd_chk(0);
		@(posedge clk);
		slp <= 1'b1;
		repeat (2) @(posedge clk);
		mdl[0] = 24'h3f0005;
		#1 chk("sleep active", 24'h000001, {23'h0, sact});
		for (int a = 0; a < 20; a++) rd_chk(a);
		@(posedge clk);
		slp <= 1'b0;
		give_verdict();
	end
endmodule : test_adc_config_register_bank
